// *** rtl/ctb_arbiter.sv ***
`timescale 1ns/100ps
`default_nettype none
module ctb_arbiter (
  input wire logic [ctb_pkg::NBUF-1:0] pending,
  input wire logic prio_mode,
  input wire logic [ctb_pkg::PRIO_W-1:0] prio [ctb_pkg::NBUF],
  input wire logic [ctb_pkg::ID_W-1:0] ident [ctb_pkg::NBUF],
  output logic any,
  output logic [1:0] sel
);
  import ctb_pkg::*;

  always_comb
  begin
    any = 1'b0;
    sel = 2'h0;
    // Ascending scan with strict compare keeps lowest number on ties
    for (int i = 0; i < NBUF; i++)
    begin
      if (pending[i])
      begin
        if (!any)
        begin
          any = 1'b1;
          sel = 2'(i);
        end
        else if (prio_mode && (prio[i] < prio[sel]))
          sel = 2'(i);
        else if (!prio_mode && (ident[i] < ident[sel]))
          sel = 2'(i);
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/ctb_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module ctb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == LAST_IDX) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = (count != FULL_CNT);
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= bump(wr_ptr);
      if (pop)
        rd_ptr <= bump(rd_ptr);
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** rtl/ctb_pkg.sv ***
package ctb_pkg;
  // Buffer count and register map
  localparam int NBUF = 3;
  localparam logic [1:0] SEL_INFO = 2'h0;
  localparam logic [1:0] SEL_IDENT = 2'h1;
  localparam logic [1:0] SEL_DATA_A = 2'h2;
  localparam logic [1:0] SEL_DATA_B = 2'h3;
  localparam logic [7:0] OFS_BUF_LAST = 8'h2c;
  localparam logic [7:0] OFS_CTRL = 8'h30;
  localparam logic [7:0] OFS_STAT = 8'h34;
  // Field positions and widths, byte limit, FIFO depth
  localparam int FF_BIT = 31;
  localparam int RTR_BIT = 30;
  localparam int DLC_LSB = 16;
  localparam int DLC_W = 4;
  localparam int PRIO_LSB = 0;
  localparam int PRIO_W = 8;
  localparam int ID_W = 29;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_REQ_LSB = 1;
  localparam int CTRL_ABORT_BIT = 4;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_CUR_LSB = 4;
  localparam logic [3:0] MAX_BYTES = 4'h8;
  localparam int FIFO_DEPTH = 8;
  typedef struct packed {
    logic frame_format_select;
    logic remote;
    logic [DLC_W-1:0] dlc;
    logic [PRIO_W-1:0] tx_priority_value;
  } ctb_info_s;
  typedef struct packed {
    logic first;
    logic last;
    logic [31:0] word;
  } ctb_item_s;
  localparam int ITEM_W = $bits(ctb_item_s);
  // Reset values
  localparam ctb_info_s INFO_RST = '{default: 1'b0};
  localparam logic [ID_W-1:0] ID_RST = 29'h0;
  localparam logic [31:0] DATA_RST = 32'h0;
  localparam logic [NBUF-1:0] RELEASED_RST = 3'h7;
  // Message info word with reserved bits at zero
  function automatic logic [31:0] info_word(input ctb_info_s i);
    logic [31:0] w;
    w = 32'h0;
    w[FF_BIT] = i.frame_format_select;
    w[RTR_BIT] = i.remote;
    w[DLC_LSB +: DLC_W] = i.dlc;
    w[PRIO_LSB +: PRIO_W] = i.tx_priority_value;
    return w;
  endfunction
  // Payload bytes actually sent
  function automatic logic [3:0] eff_len(input ctb_info_s i);
    if (i.remote)
      return 4'h0;
    return (i.dlc > MAX_BYTES) ? MAX_BYTES : i.dlc;
  endfunction
endpackage

// *** rtl/ctb_top.sv ***
// Behaviour
// - Three buffers, each with info and identifier
// - Buffer writes accepted only while buffer released
// - Info bit 31 selects extended frame format
// - Info bit 30 selects remote frame
// - Bits 19..16 hold data length code
// - Length codes above eight send eight bytes
// - Priority mode sends lowest priority value first
// - Ties go to lowest buffer number
// - Identifier bits 28..0, reset zero
// - Reserved bits always read as zero
// - Two data words per buffer, sent up to length
`timescale 1ns/100ps
`default_nettype none
module ctb_top (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  output ctb_pkg::ctb_item_s TX_ITEM
);
  import ctb_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INFO = 2'b01,
    ST_IDENT = 2'b11,
    ST_DATA = 2'b10
  } ctb_state_e;

  ctb_info_s info [NBUF];
  logic [ID_W-1:0] ident [NBUF];
  logic [31:0] data_a [NBUF];
  logic [31:0] data_b [NBUF];
  logic [PRIO_W-1:0] prio [NBUF];
  logic [NBUF-1:0] released;
  logic prio_mode;
  ctb_state_e state;
  ctb_state_e next_state;
  logic [1:0] cur;
  logic [3:0] nbytes;
  logic [2:0] byte_idx;
  logic arb_any;
  logic [1:0] arb_sel;
  logic push_valid;
  logic push_ready;
  ctb_item_s push_item;
  logic push;
  logic done;
  logic [63:0] payload;
  logic [NBUF-1:0] req_set;
  logic [NBUF-1:0] abort_set;
  logic ctrl_wr;

  // Buffer register decode
  function automatic logic buf_hit(input logic [7:0] a);
    return (a <= OFS_BUF_LAST) && (a[1:0] == 2'h0) && (a[5:4] != 2'h3) && (a[7:6] == 2'h0);
  endfunction

  // Full read value of one buffer register
  function automatic logic [31:0] buf_read(input logic [1:0] b, input logic [1:0] r);
    logic [31:0] v;
    v = 32'h0;
    case (r)
      SEL_INFO: v = info_word(info[b]);
      SEL_IDENT: v = {3'h0, ident[b]};
      SEL_DATA_A: v = data_a[b];
      SEL_DATA_B: v = data_b[b];
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  assign ctrl_wr = REG_WR && (REG_ADDR == OFS_CTRL);

  // Buffer registers, writable only while released
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      for (int b = 0; b < NBUF; b++)
      begin
        info[b] <= INFO_RST;
        ident[b] <= ID_RST;
        data_a[b] <= DATA_RST;
        data_b[b] <= DATA_RST;
      end
    end
    else if (REG_WR && buf_hit(REG_ADDR) && released[REG_ADDR[5:4]])
    begin
      case (REG_ADDR[3:2])
        SEL_INFO:
        begin
          info[REG_ADDR[5:4]].frame_format_select <= REG_WDATA[FF_BIT];
          info[REG_ADDR[5:4]].remote <= REG_WDATA[RTR_BIT];
          info[REG_ADDR[5:4]].dlc <= REG_WDATA[DLC_LSB +: DLC_W];
          info[REG_ADDR[5:4]].tx_priority_value <= REG_WDATA[PRIO_LSB +: PRIO_W];
        end
        SEL_IDENT: ident[REG_ADDR[5:4]] <= REG_WDATA[ID_W-1:0];
        SEL_DATA_A: data_a[REG_ADDR[5:4]] <= REG_WDATA;
        SEL_DATA_B: data_b[REG_ADDR[5:4]] <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // Priority mode control bit
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      prio_mode <= 1'b0;
    else if (ctrl_wr)
      prio_mode <= REG_WDATA[CTRL_MODE_BIT];
  end

  // Request and abort only act on eligible buffers
  always_comb
  begin
    req_set = '0;
    abort_set = '0;
    for (int b = 0; b < NBUF; b++)
    begin
      req_set[b] = ctrl_wr && REG_WDATA[CTRL_REQ_LSB + b] && released[b];
      abort_set[b] = ctrl_wr && REG_WDATA[CTRL_ABORT_BIT] && !released[b] &&
                     !((state != ST_IDLE) && (cur == 2'(b)));
    end
  end

  // Release status: completion or abort sets, request clears
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      released <= RELEASED_RST;
    else
    begin
      for (int b = 0; b < NBUF; b++)
      begin
        if ((done && (cur == 2'(b))) || abort_set[b])
          released[b] <= 1'b1;
        else if (req_set[b])
          released[b] <= 1'b0;
      end
    end
  end

  always_comb
  begin
    for (int b = 0; b < NBUF; b++)
      prio[b] = info[b].tx_priority_value;
  end

  ctb_arbiter u_arbiter (
    .pending(~released),
    .prio_mode(prio_mode),
    .prio(prio),
    .ident(ident),
    .any(arb_any),
    .sel(arb_sel)
  );

  assign payload = {data_b[cur], data_a[cur]};
  assign push_valid = (state != ST_IDLE);
  assign push = push_valid && push_ready;
  assign done = push && push_item.last;

  // Item formed for the current state
  always_comb
  begin
    push_item = '{default: 1'b0};
    case (state)
      ST_INFO:
      begin
        push_item.first = 1'b1;
        push_item.word = info_word(info[cur]);
      end
      ST_IDENT:
      begin
        push_item.last = (nbytes == 4'h0);
        push_item.word = {3'h0, ident[cur]};
      end
      ST_DATA:
      begin
        push_item.last = ({1'b0, byte_idx} == nbytes - 4'h1);
        push_item.word = {24'h0, payload[{byte_idx, 3'h0} +: 8]};
      end
      default: push_item = '{default: 1'b0};
    endcase
  end

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (arb_any)
          next_state = ST_INFO;
      ST_INFO:
        if (push)
          next_state = ST_IDENT;
      ST_IDENT:
        if (push)
          next_state = (nbytes == 4'h0) ? ST_IDLE : ST_DATA;
      ST_DATA:
        if (done)
          next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Latch winner and its sent length at frame start
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      cur <= 2'h0;
      nbytes <= 4'h0;
    end
    else if (state == ST_IDLE && arb_any)
    begin
      cur <= arb_sel;
      nbytes <= eff_len(info[arb_sel]);
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      byte_idx <= 3'h0;
    else if (state == ST_IDLE)
      byte_idx <= 3'h0;
    else if (state == ST_DATA && push)
      byte_idx <= byte_idx + 3'h1;
  end

  ctb_fifo #(
    .WIDTH(ITEM_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_item),
    .out_valid(TX_VALID),
    .out_ready(TX_READY),
    .out_data(TX_ITEM)
  );

  // Registered read data, zero for unmapped addresses
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      REG_RDATA <= 32'h0;
    else if (REG_RD)
    begin
      if (buf_hit(REG_ADDR))
        REG_RDATA <= buf_read(REG_ADDR[5:4], REG_ADDR[3:2]);
      else if (REG_ADDR == OFS_CTRL)
        REG_RDATA <= {31'h0, prio_mode};
      else if (REG_ADDR == OFS_STAT)
        REG_RDATA <= {26'h0, cur, (state != ST_IDLE), released};
      else
        REG_RDATA <= 32'h0;
    end
    else
      REG_RDATA <= 32'h0;
  end
endmodule
`default_nettype wire

// *** tb/ctb_sink.sv ***
`timescale 1ns/100ps
`default_nettype none
module ctb_sink (
  input wire logic clk,
  input wire logic stall,
  input wire logic slow,
  output logic ready
);
  // Ready is registered; slow mode halves the accept rate
  always_ff @(posedge clk)
  begin
    ready <= !stall && !(slow && ready);
  end
endmodule
`default_nettype wire

// *** tb/ctb_top_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module ctb_top_sva (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire ctb_pkg::ctb_item_s TX_ITEM
);
  import ctb_pkg::*;
  logic [3:0] idx;
  logic [3:0] nb;
  logic acc;
  assign acc = TX_VALID && TX_READY;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);
  // Item index inside the frame
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      idx <= 4'h0;
    else if (acc)
      idx <= TX_ITEM.first ? 4'h1 : idx + 4'h1;
  end
  // Bytes the current frame should carry
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      nb <= 4'h0;
    else if (acc && TX_ITEM.first)
      nb <= TX_ITEM.word[30] ? 4'h0 : (TX_ITEM.word[19:16] > 4'h8 ? 4'h8 : TX_ITEM.word[19:16]);
  end
  a_rdata_quiet: assert property (!REG_RD |=> REG_RDATA == 32'h0)
    else $error("read data not zero outside read");
  a_info_resv: assert property (REG_RD && REG_ADDR <= 8'h2c && REG_ADDR[3:0] == 4'h0 |=>
    REG_RDATA[29:20] == 10'h0 && REG_RDATA[15:8] == 8'h0) else $error("info reserved bits set");
  a_id_resv: assert property (REG_RD && REG_ADDR <= 8'h2c && REG_ADDR[3:0] == 4'h4 |=>
    REG_RDATA[31:29] == 3'h0) else $error("id reserved bits set");
  a_item_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_ITEM))
    else $error("item changed while stalled");
  a_first_resv: assert property (TX_VALID && TX_ITEM.first |-> !TX_ITEM.last &&
    TX_ITEM.word[29:20] == 10'h0 && TX_ITEM.word[15:8] == 8'h0) else $error("bad info item");
  a_id_item: assert property (TX_VALID && idx == 4'h1 |-> !TX_ITEM.first &&
    TX_ITEM.word[31:29] == 3'h0) else $error("bad identifier item");
  a_byte_item: assert property (TX_VALID && !TX_ITEM.first && idx >= 4'h2 |->
    idx <= 4'h9 && TX_ITEM.word[31:8] == 24'h0) else $error("bad data item");
  a_last_count: assert property (TX_VALID && !TX_ITEM.first && idx != 4'h0 |->
    TX_ITEM.last == (idx == nb + 4'h1)) else $error("frame length wrong");
  c_frame_end: cover property (acc && TX_ITEM.last);
  c_stall: cover property ((TX_VALID && !TX_READY) [*3]);
  c_clamp: cover property (acc && TX_ITEM.first && TX_ITEM.word[19:16] > 4'h8);
endmodule
bind ctb_top ctb_top_sva CHK_I (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_ITEM(TX_ITEM));
`default_nettype wire

// *** tb/ctb_top_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("ERROR %s exp %h got %h", n, e, g); end end
module ctb_top_test;
  import ctb_pkg::*;
  logic CORE_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [7:0] REG_ADDR = 8'h0;
  logic [31:0] REG_WDATA = 32'h0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [31:0] REG_RDATA;
  logic TX_VALID;
  logic TX_READY;
  ctb_item_s TX_ITEM;
  logic stall = 1'b0;
  logic slow = 1'b0;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  ctb_item_s got [$];
  logic [31:0] rd_val;
  // Buffer, info, id, data A, data B, info back, byte count, id back
  logic [31:0] rows [4][8] = '{
    '{32'h0, 32'h0008_0005, 32'h7ff, 32'h4433_2211, 32'h8877_6655, 32'h0008_0005, 32'h8, 32'h7ff},
    '{32'h1, 32'hffff_ffff, 32'hffff_ffff, 32'h0, 32'h0, 32'hc00f_00ff, 32'h0, 32'h1fff_ffff},
    '{32'h2, 32'h000f_0000, 32'h123, 32'hddcc_bbaa, 32'h1122_3344, 32'h000f_0000, 32'h8, 32'h123},
    '{32'h0, 32'h8003_0000, 32'h1234_5678, 32'h0055_6677, 32'h0, 32'h8003_0000, 32'h3, 32'h1234_5678}};
  ctb_top DUT (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .TX_ITEM(TX_ITEM));
  ctb_sink PARTNER (.clk(CORE_CLK), .stall(stall), .slow(slow), .ready(TX_READY));
  initial
  begin
    forever #50 CORE_CLK = ~CORE_CLK;
  end
  // Collects accepted items and cuts a hang short
  always @(posedge CORE_CLK)
  begin
    cycles++;
    if (TX_VALID === 1'b1 && TX_READY === 1'b1)
      got.push_back(TX_ITEM);
    if (cycles == 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    @(posedge CORE_CLK);
    rd_val = REG_RDATA;
  endtask
  task automatic waitn(input int n);
    for (int t = 0; t < 100 && got.size() < n; t++)
      @(posedge CORE_CLK);
  endtask
  task automatic chkf(input int r);
    logic [3:0] n;
    logic [63:0] pay;
    n = rows[r][6][3:0];
    pay = {rows[r][4], rows[r][3]};
    waitn(n + 2);
    repeat (12) @(posedge CORE_CLK);
    `CHK("frame size", n + 4'h2, 4'(got.size()))
    `CHK("info item", {2'b10, rows[r][5]}, got[0])
    `CHK("id item", {1'b0, n == 4'h0, rows[r][7]}, got[1])
    for (int k = 0; k < n; k++)
      `CHK("data item", {1'b0, 1'(k == n - 1), 24'h0, pay[8 * k +: 8]}, got[k + 2])
  endtask
  function automatic logic [31:0] idv(input int m, input int b);
    return m ? 32'(16 + b) : (b != 0 ? 32'h5 : 32'h7);
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    for (int r = 0; r < 4; r++)
    begin
      for (int k = 1; k < 5; k++)
        wr({rows[r][0][3:0], 4'h0} + 8'(4 * k - 4), rows[r][k]);
      rd({rows[r][0][3:0], 4'h0});
      `CHK("info back", rows[r][5], rd_val)
      rd({rows[r][0][3:0], 4'h4});
      `CHK("id back", rows[r][7], rd_val)
      got.delete();
      wr(OFS_CTRL, 32'h2 << rows[r][0]);
      chkf(r);
      $display("row %0d done", r);
    end
    // Refused writes while pending, full FIFO, slow consumer
    for (int k = 1; k < 5; k++)
      wr(8'(4 * k - 4), rows[0][k]);
    stall <= 1'b1;
    got.delete();
    wr(OFS_CTRL, 32'h2);
    wr(8'h00, 32'h0);
    wr(OFS_CTRL, 32'h4);
    rd(OFS_STAT);
    `CHK("pending status", 6'h0c, rd_val[5:0])
    wr(OFS_CTRL, 32'h10);
    rd(OFS_STAT);
    `CHK("abort status", 6'h0e, rd_val[5:0])
    rd(8'h00);
    `CHK("refused write", rows[0][5], rd_val)
    rd(8'h40);
    `CHK("unmapped read", 32'h0, rd_val)
    slow <= 1'b1;
    stall <= 1'b0;
    chkf(0);
    slow <= 1'b0;
    $display("pending test done");
    // Selection by priority value and by identifier
    for (int m = 0; m < 2; m++)
    begin
      for (int b = 0; b < 3; b++)
      begin
        wr(8'(16 * b), m ? (b != 0 ? 32'h3 : 32'h9) : 32'(b + 1));
        wr(8'(16 * b + 4), idv(m, b));
      end
      got.delete();
      wr(OFS_CTRL, 32'he | 32'(m));
      waitn(6);
      for (int k = 0; k < 3; k++)
        `CHK("winner order", {2'b01, idv(m, (k + 1) % 3)}, got[2 * k + 1])
      $display("selection mode %0d done", m);
    end
    rd(OFS_CTRL);
    `CHK("mode back", 32'h1, rd_val)
    // Mid-run reset returns status, buffer 1 info and identifier, and mode to their reset values
    @(posedge CORE_CLK);
    SYS_RST <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    rd(OFS_STAT);
    `CHK("reset status", 32'h7, rd_val)
    rd(8'h10);
    `CHK("reset info", 32'h0, rd_val)
    rd(8'h14);
    `CHK("reset id", 32'h0, rd_val)
    rd(OFS_CTRL);
    `CHK("reset mode", 32'h0, rd_val)
    $display("reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
